// ### scc_pkg.sv
// constants, enumerations and state record of the smart-card channel controller
package scc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int SEQ_GAP_NS    = 200;
    // least time, so round up
    localparam int SEQ_GAP_CYC   = (SEQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W         = 8;
    localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(SEQ_GAP_CYC - 1);

    // ------------------------------------------------------------------
    // synchronised pin positions
    // ------------------------------------------------------------------
    localparam int NPIN     = 6;
    localparam int PIN_SCL  = 0;
    localparam int PIN_SDA  = 1;
    localparam int PIN_HDAT = 2;
    localparam int PIN_HCLK = 3;
    localparam int PIN_HRST = 4;
    localparam int PIN_UNDERVOLTAGE_LOCKOUT = 5;

    // ------------------------------------------------------------------
    // control byte layout and values
    // ------------------------------------------------------------------
    localparam int CTL_EN    = 0;
    localparam int CTL_POL   = 3;
    localparam int CTL_LATCH = 4;
    localparam int CTL_RSTV  = 5;
    localparam int CTL_MODE  = 6;
    localparam logic [7:0] CTL_RESET    = 8'h00;
    localparam logic [6:0] DEV_ADDR     = 7'h60;
    localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
    localparam logic [7:0] SWRST_BYTE   = 8'h06;
    localparam logic [3:0] BYTE_BITS    = 4'h8;

    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_ACKA = 3'b010,
        I_WDAT = 3'b011,
        I_ACKD = 3'b100,
        I_RDAT = 3'b101,
        I_RACK = 3'b110,
        I_SKIP = 3'b111
    } scc_i2c_e;

    typedef enum logic [2:0] {
        S_OFF = 3'b000,
        S_UP  = 3'b001,
        S_ON  = 3'b010,
        S_CLK = 3'b011,
        S_DAT = 3'b100,
        S_SUP = 3'b101
    } scc_seq_e;

    typedef struct packed {
        logic [NPIN-1:0]  m;       // first sync stage
        logic [NPIN-1:0]  s;       // second sync stage
        logic [NPIN-1:0]  p;       // previous of s
        scc_i2c_e         ist;
        logic [3:0]       bitn;
        logic [7:0]       sh;
        logic             sda_oe;
        logic             rd;
        logic             gc;
        logic             gc_seen;
        logic             arm;
        logic [7:0]       ctl;
        logic [7:0]       pend;
        logic             pend_v;
        scc_seq_e         seq;
        logic [GAP_W-1:0] cnt;
        logic             uv;
        logic [3:0]       chan_en; // supply, data, clock, reset
        logic             lat_p;
        logic             lat_d;
        logic             lat_c;
        logic             lat_r;
        logic             rst_o;
        logic             clk_o;
        logic             dat_oe;
    } scc_st_s;

    localparam int CH_RST = 0;
    localparam int CH_CLK = 1;
    localparam int CH_DAT = 2;
    localparam int CH_SUP = 3;

endpackage

// ### scc_ctrl.sv
// smart-card channel controller: i2c control, enable modes, latch and shutdown
//
// Contract
// - undervoltage starts the card shutdown at once, with no command.
// - undervoltage shutdown drops reset, waits, drops clock and data, then supply.
// - every card channel is pulled low and shutdown completes in under a microsecond.
// - shutdown also on pin deassert in pin mode, or enable bit cleared.
// - enable shutdown drops reset, then clock, data and supply one by one.
// - enable or disable writes take effect at the end of the transfer.
// - with pin mode off the host reset pin passes straight to card reset.
// - with pin mode on the host reset pin acts as hardware enable.
// - in pin mode the card reset level comes from the reset value bit.
// - in pin mode the enable bit is ignored.
// - in pin mode reading the enable bit returns the pin enable state, the pin level xor the polarity bit.
// - the polarity bit selects active high or active low pin enable.
// - setting the latch bit captures host levels and holds them on card.
// - general call is acknowledged only with write direction.
// - after general call only a byte equal to 06h is acknowledged.
// - every byte after the first following general call gets no acknowledge.
// - stop after an acknowledged reset byte restores power-up register values.
// - a repeated start after the reset byte cancels the software reset.
`timescale 1ns/100ps
module scc_ctrl
    import scc_pkg::*;
(
    input  wire logic       clk_i,                  // 250 MHz clock
    input  wire logic       rst_i,                  // async reset, active high
    input  wire logic       scl_i,                  // i2c clock pin
    input  wire logic       sda_i,                  // i2c data pin level
    output logic            sda_o,                  // i2c data drive value
    output logic            sda_oe_o,               // i2c data pull low enable
    input  wire logic       host_data_i,            // host data pin
    input  wire logic       host_clock_i,           // host clock pin
    input  wire logic       host_rst_en_i,          // host reset or enable pin
    input  wire logic       undervoltage_lockout_i, // host supply below threshold
    output logic            card_reset_out_o,       // card reset
    output logic            card_clock_out_o,       // card clock
    output logic            card_data_io_o,         // card data drive value
    output logic            card_data_io_oe_o,      // card data pull low enable
    output logic            card_supply_o,          // card supply switch on
    output logic [3:0]      card_pulldown_o,        // pull-downs: supply,data,clock,reset
    output logic            device_active_o         // enable condition met
);

    scc_st_s q;
    scc_st_s d;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic pin_enable(input logic pin, input logic [7:0] ctl);
        pin_enable = pin ^ ctl[CTL_POL];
    endfunction

    function automatic logic [7:0] read_value(input logic pin, input logic [7:0] ctl);
        read_value = ctl;
        if (ctl[CTL_MODE]) begin
            read_value[CTL_EN] = pin;
        end
    endfunction

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic active;
    logic src_r;
    logic src_c;
    logic src_d;
    logic gap_done;

    always_comb begin
        scl_rise  = q.s[PIN_SCL] & ~q.p[PIN_SCL];
        scl_fall  = ~q.s[PIN_SCL] & q.p[PIN_SCL];
        bus_start = q.s[PIN_SCL] & q.p[PIN_SCL] & ~q.s[PIN_SDA] & q.p[PIN_SDA];
        bus_stop  = q.s[PIN_SCL] & q.p[PIN_SCL] & q.s[PIN_SDA] & ~q.p[PIN_SDA];
        gap_done  = (q.cnt == GAP_LAST);
        if (q.ctl[CTL_MODE]) begin
            active = pin_enable(q.s[PIN_HRST], q.ctl);
        end else begin
            active = q.ctl[CTL_EN];
        end
        active = active & ~q.s[PIN_UNDERVOLTAGE_LOCKOUT];
        // held levels replace the live host levels once the capture has landed,
        // so the cycle of the latch edge shows live levels, not stale ones
        src_c = (q.ctl[CTL_LATCH] & q.lat_p) ? q.lat_c : q.s[PIN_HCLK];
        src_d = (q.ctl[CTL_LATCH] & q.lat_p) ? q.lat_d : q.s[PIN_HDAT];
        if (q.ctl[CTL_MODE]) begin
            src_r = q.ctl[CTL_RSTV];
        end else begin
            src_r = (q.ctl[CTL_LATCH] & q.lat_p) ? q.lat_r : q.s[PIN_HRST];
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        d   = q;
        d.m = {undervoltage_lockout_i, host_rst_en_i, host_clock_i,
               host_data_i, sda_i, scl_i};
        d.s = q.m;
        d.p = q.s;

        // i2c slave
        if (bus_start) begin
            d.ist     = I_ADDR;
            d.bitn    = 4'h0;
            d.sda_oe  = 1'b0;
            d.gc      = 1'b0;
            d.gc_seen = 1'b0;
            d.arm     = 1'b0;
            d.pend_v  = 1'b0;
        end else if (bus_stop) begin
            d.ist    = I_IDLE;
            d.sda_oe = 1'b0;
            d.pend_v = 1'b0;
            if (q.arm) begin
                d.ctl = CTL_RESET;
                d.arm = 1'b0;
            end else if (q.pend_v) begin
                d.ctl = q.pend;
            end
        end else begin
            case (q.ist)
                I_ADDR, I_WDAT: begin
                    if (scl_rise) begin
                        d.sh   = {q.sh[6:0], q.s[PIN_SDA]};
                        d.bitn = q.bitn + 4'h1;
                    end else if (scl_fall && q.bitn == BYTE_BITS) begin
                        d.bitn = 4'h0;
                        if (q.ist == I_ADDR) begin
                            if (q.sh[7:1] == DEV_ADDR) begin
                                d.ist    = I_ACKA;
                                d.sda_oe = 1'b1;
                                d.rd     = q.sh[0];
                            end else if (q.sh == GC_ADDR_BYTE) begin
                                d.ist    = I_ACKA;
                                d.sda_oe = 1'b1;
                                d.rd     = 1'b0;
                                d.gc     = 1'b1;
                            end else begin
                                d.ist = I_SKIP;
                            end
                        end else if (q.gc) begin
                            // only the first byte may arm the reset
                            d.arm     = ~q.gc_seen & (q.sh == SWRST_BYTE);
                            d.gc_seen = 1'b1;
                            d.sda_oe  = ~q.gc_seen & (q.sh == SWRST_BYTE);
                            d.ist     = I_ACKD;
                        end else begin
                            d.pend   = q.sh;
                            d.pend_v = 1'b1;
                            d.sda_oe = 1'b1;
                            d.ist    = I_ACKD;
                        end
                    end
                end
                I_ACKA: begin
                    if (scl_fall) begin
                        d.bitn = 4'h0;
                        if (q.rd) begin
                            d.sh     = read_value(pin_enable(q.s[PIN_HRST], q.ctl), q.ctl);
                            d.sda_oe = ~d.sh[7];
                            d.ist    = I_RDAT;
                        end else begin
                            d.sda_oe = 1'b0;
                            d.ist    = I_WDAT;
                        end
                    end
                end
                I_ACKD: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        d.ist    = I_WDAT;
                    end
                end
                I_RDAT: begin
                    if (scl_rise) begin
                        d.bitn = q.bitn + 4'h1;
                    end else if (scl_fall) begin
                        if (q.bitn == BYTE_BITS) begin
                            d.sda_oe = 1'b0;
                            d.ist    = I_RACK;
                        end else begin
                            d.sda_oe = ~q.sh[3'(4'h7 - q.bitn)];
                        end
                    end
                end
                I_RACK: begin
                    if (scl_rise) begin
                        d.ist = q.s[PIN_SDA] ? I_SKIP : I_ACKA;
                        d.rd  = 1'b1;
                    end
                end
                I_IDLE, I_SKIP: begin
                    d.sda_oe = 1'b0;
                end
                default: begin
                    d.ist    = I_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end

        // clock-stop capture on the rising edge of the latch bit
        d.lat_p = q.ctl[CTL_LATCH];
        if (q.ctl[CTL_LATCH] && !q.lat_p) begin
            d.lat_d = q.s[PIN_HDAT];
            d.lat_c = q.s[PIN_HCLK];
            d.lat_r = q.s[PIN_HRST];
        end

        // channel sequencer
        d.cnt = gap_done ? '0 : q.cnt + GAP_W'(1);
        case (q.seq)
            S_OFF: begin
                d.chan_en = 4'h0;
                if (active) begin
                    d.chan_en[CH_SUP] = 1'b1;
                    d.cnt             = '0;
                    d.seq             = S_UP;
                end
            end
            S_UP: begin
                if (!active) begin
                    d.chan_en = 4'h0;
                    d.seq     = S_OFF;
                end else if (gap_done) begin
                    d.chan_en = 4'hf;
                    d.seq     = S_ON;
                end
            end
            S_ON: begin
                if (!active) begin
                    d.chan_en[CH_RST] = 1'b0;
                    d.uv              = q.s[PIN_UNDERVOLTAGE_LOCKOUT];
                    d.cnt             = '0;
                    d.seq             = S_CLK;
                end
            end
            S_CLK: begin
                if (gap_done) begin
                    d.chan_en[CH_CLK] = 1'b0;
                    if (q.uv) begin
                        d.chan_en[CH_DAT] = 1'b0;
                        d.seq             = S_SUP;
                    end else begin
                        d.seq = S_DAT;
                    end
                end
            end
            S_DAT: begin
                if (gap_done) begin
                    d.chan_en[CH_DAT] = 1'b0;
                    d.seq             = S_SUP;
                end
            end
            S_SUP: begin
                if (gap_done) begin
                    d.chan_en[CH_SUP] = 1'b0;
                    d.seq             = S_OFF;
                end
            end
            default: begin
                d.chan_en = 4'h0;
                d.seq     = S_OFF;
            end
        endcase

        // output stage; a disabled channel is held low
        d.rst_o  = d.chan_en[CH_RST] & src_r;
        d.clk_o  = d.chan_en[CH_CLK] & src_c;
        d.dat_oe = ~d.chan_en[CH_DAT] | ~src_d;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q         <= '0;
            q.m       <= {NPIN{1'b1}};
            q.s       <= {NPIN{1'b1}};
            q.p       <= {NPIN{1'b1}};
            q.ist     <= I_IDLE;
            q.ctl     <= CTL_RESET;
            q.seq     <= S_OFF;
            q.dat_oe  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign sda_o             = 1'b0;
    assign sda_oe_o          = q.sda_oe;
    assign card_reset_out_o  = q.rst_o;
    assign card_clock_out_o  = q.clk_o;
    assign card_data_io_o    = 1'b0;
    assign card_data_io_oe_o = q.dat_oe;
    assign card_supply_o     = q.chan_en[CH_SUP];
    assign card_pulldown_o   = ~q.chan_en;
    assign device_active_o   = active;

endmodule

// ### scc_ctrl_props.sv
// port assertions of the smart-card channel controller
`timescale 1ns/100ps
module scc_ctrl_props (
    input wire logic       clk_i,                  // clock
    input wire logic       rst_i,                  // async reset
    input wire logic       scl_i,                  // i2c clock pin
    input wire logic       sda_oe_o,               // device pulls sda
    input wire logic       undervoltage_lockout_i, // supply low
    input wire logic       card_reset_out_o,       // card reset
    input wire logic       card_clock_out_o,       // card clock
    input wire logic       card_data_io_oe_o,      // card data low
    input wire logic       card_supply_o,          // card supply on
    input wire logic [3:0] card_pulldown_o,        // channel off flags
    input wire logic       device_active_o         // enable met
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_uv_active: assert property (
        $rose(undervoltage_lockout_i) |-> ##[1:6] !device_active_o)
        else $error("active kept in undervoltage");
    a_reset_first: assert property (
        $fell(device_active_o) |-> ##[1:4] card_pulldown_o[0])
        else $error("reset channel late");
    // one cycle of slack between the pull-down flag and its output register
    a_chan_low: assert property (
        ($past(card_pulldown_o) & card_pulldown_o & {card_supply_o,
        !card_data_io_oe_o, card_clock_out_o, card_reset_out_o}) == 4'h0)
        else $error("channel high while off");
    a_reset_clk_gap: assert property (
        $rose(card_pulldown_o[0]) |-> ##[48:52] $rose(card_pulldown_o[1]))
        else $error("reset to clock gap");
    a_clk_dat_gap: assert property (
        $rose(card_pulldown_o[1]) && !card_pulldown_o[2]
        |-> ##[48:52] $rose(card_pulldown_o[2]))
        else $error("clock to data gap");
    a_uv_together: assert property (
        $rose(card_pulldown_o[1]) && undervoltage_lockout_i |-> card_pulldown_o[2])
        else $error("clock and data apart");
    a_dat_sup_gap: assert property (
        $rose(card_pulldown_o[2]) |-> ##[48:52] $fell(card_supply_o))
        else $error("data to supply gap");
    a_sda_change: assert property (
        $changed(sda_oe_o) |-> !scl_i)
        else $error("sda moved while scl high");
endmodule

// ### scc_host_model.sv
// i2c master side of the host controller
`timescale 1ns/100ps
module scc_host_model (
    input  wire logic clk_i,   // bench clock
    input  wire logic sda_i,   // resolved sda wire
    output logic      scl_o,   // i2c clock, idles high
    output logic      sda_oe_o // master pulls sda low
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // quarter of the 160 ns bit time
    task automatic q();
        repeat (10) @(posedge clk_i);
    endtask

    // start, or repeated start from a low clock
    task automatic start_c();
        @(posedge clk_i);
        sda_oe_o <= 1'b0;
        q();
        scl_o <= 1'b1;
        q();
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b0;
        q();
    endtask

    task automatic stop_c();
        @(posedge clk_i);
        sda_oe_o <= 1'b1;
        q();
        scl_o <= 1'b1;
        q();
        sda_oe_o <= 1'b0;
        q();
        q();
    endtask

    // nine clocks msb first; bit 0 is the acknowledge slot
    task automatic byte_x(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_oe_o <= !tx[i];
            q();
            scl_o <= 1'b1;
            q();
            rx[i] = sda_i;
            q();
            scl_o <= 1'b0;
            q();
        end
    endtask
endmodule

// ### tb_top.sv
// self-checking bench of the smart-card channel controller
`timescale 1ns/100ps
module tb_top
    import scc_pkg::*;
;

    typedef struct packed {
        logic [7:0] ctl;
        logic       pin;
        logic       act;
        logic       rst;
    } scc_row_s;

    // ----
    // rows: control byte, pin level, expected active and card reset
    // ----
    localparam scc_row_s ROWS [9] = '{
        '{8'h01, 1'b0, 1'b1, 1'b0},
        '{8'h01, 1'b1, 1'b1, 1'b1},
        '{8'h40, 1'b1, 1'b1, 1'b0},
        '{8'h60, 1'b1, 1'b1, 1'b1},
        '{8'h60, 1'b0, 1'b0, 1'b0},
        '{8'h41, 1'b0, 1'b0, 1'b0},
        '{8'h00, 1'b1, 1'b0, 1'b0},
        '{8'h68, 1'b1, 1'b0, 1'b0},
        '{8'h68, 1'b0, 1'b1, 1'b1}
    };

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       hrst = 1'b0;
    logic       uv = 1'b0;
    logic       hdat = 1'b0;
    logic       hclk = 1'b0;
    logic       scl, m_oe, sda_oe, c_rst, c_clk, c_doe, c_sup, act;
    logic [3:0] pd;
    logic [8:0] rx;
    logic [7:0] d;
    wire        sda = !(m_oe || sda_oe);
    int         miscompares = 0;
    int         check_count = 0;

    always #2 clk = ~clk;

    scc_ctrl scc_ctrl_i (.clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(sda_oe), .host_data_i(hdat), .host_clock_i(hclk), .host_rst_en_i(hrst),
        .undervoltage_lockout_i(uv), .card_reset_out_o(c_rst), .card_clock_out_o(c_clk),
        .card_data_io_o(), .card_data_io_oe_o(c_doe), .card_supply_o(c_sup),
        .card_pulldown_o(pd), .device_active_o(act));
    scc_host_model scc_host_model_i (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

    // ----
    // helpers
    // ----
    task automatic chk_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_vec(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tx(input logic [7:0] b, input logic ack_e);
        scc_host_model_i.byte_x({b, 1'b1}, rx);
        chk_bit("ack", !ack_e, rx[0]);
    endtask

    // settles long enough for a full power-up or shutdown
    task automatic wr_ctl(input logic [7:0] v);
        scc_host_model_i.start_c();
        tx({DEV_ADDR, 1'b0}, 1'b1);
        tx(v, 1'b1);
        scc_host_model_i.stop_c();
        repeat (300) @(negedge clk);
    endtask

    task automatic rd_ctl(output logic [7:0] v);
        scc_host_model_i.start_c();
        tx({DEV_ADDR, 1'b1}, 1'b1);
        scc_host_model_i.byte_x({8'hff, 1'b1}, rx);
        v = rx[8:1];
        scc_host_model_i.stop_c();
    endtask

    // e holds three pull-down snapshots, one per gap after the clock drops
    task automatic shut_chk(input logic [11:0] e);
        int n;
        n = 0;
        while (pd[1] !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        for (int s = 0; s < 3; s++) begin
            repeat (s == 0 ? 25 : 50) @(negedge clk);
            chk_vec("pulldowns", {4'h0, e[11-4*s -: 4]}, {4'h0, pd});
        end
    endtask

    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        chk_vec("reset pulldowns", 8'h0f, {4'h0, pd});
        foreach (ROWS[k]) begin
            @(posedge clk);
            hrst <= ROWS[k].pin;
            wr_ctl(ROWS[k].ctl);
            chk_bit("active", ROWS[k].act, act);
            chk_bit("supply", ROWS[k].act, c_sup);
            chk_bit("card reset", ROWS[k].rst, c_rst);
        end
        rd_ctl(d);
        chk_vec("pin state read", 8'h69, d);
        @(posedge clk);
        hrst <= 1'b1;
        wr_ctl(8'h01);
        scc_host_model_i.start_c();
        tx({DEV_ADDR, 1'b0}, 1'b1);
        tx(8'h00, 1'b1);
        repeat (40) @(negedge clk);
        chk_bit("active before stop", 1'b1, act);
        scc_host_model_i.stop_c();
        shut_chk(12'h37f);
        wr_ctl(8'h01);
        @(posedge clk);
        uv <= 1'b1;
        repeat (6) @(negedge clk);
        chk_bit("active in undervoltage", 1'b0, act);
        shut_chk(12'h7ff);
        @(posedge clk);
        uv <= 1'b0;
        wr_ctl(8'h01);
        @(posedge clk);
        hclk <= 1'b1;
        hdat <= 1'b1;
        repeat (8) @(negedge clk);
        chk_bit("card clock live", 1'b1, c_clk);
        chk_bit("card data live", 1'b0, c_doe);
        wr_ctl(8'h11);
        @(posedge clk);
        hclk <= 1'b0;
        hdat <= 1'b0;
        hrst <= 1'b0;
        repeat (8) @(negedge clk);
        chk_bit("held card clock", 1'b1, c_clk);
        chk_bit("held card data", 1'b0, c_doe);
        chk_bit("held card reset", 1'b1, c_rst);
        wr_ctl(8'h01);
        chk_bit("released card clock", 1'b0, c_clk);
        chk_bit("released card reset", 1'b0, c_rst);
        // a high host clock level makes the later shutdown show its pull-down
        @(posedge clk);
        hclk <= 1'b1;
        // a missing acknowledge aborts, so each attempt restarts
        scc_host_model_i.start_c();
        tx(8'h01, 1'b0);
        scc_host_model_i.start_c();
        tx(8'h00, 1'b1);
        tx(8'h07, 1'b0);
        scc_host_model_i.start_c();
        tx(8'h00, 1'b1);
        tx(8'h06, 1'b1);
        tx(8'h06, 1'b0);
        scc_host_model_i.start_c();
        tx(8'h00, 1'b1);
        tx(8'h06, 1'b1);
        scc_host_model_i.start_c();
        scc_host_model_i.stop_c();
        repeat (100) @(negedge clk);
        chk_bit("active kept", 1'b1, act);
        scc_host_model_i.start_c();
        tx(8'h00, 1'b1);
        tx(8'h06, 1'b1);
        scc_host_model_i.stop_c();
        repeat (20) @(negedge clk);
        chk_bit("active after soft reset", 1'b0, act);
        rd_ctl(d);
        chk_vec("control after soft reset", CTL_RESET, d);
        chk_bit("card clock after soft reset", 1'b0, c_clk);
        wrap_up();
    end
endmodule

bind scc_ctrl scc_ctrl_props scc_ctrl_props_i (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
    .sda_oe_o(sda_oe_o), .undervoltage_lockout_i(undervoltage_lockout_i),
    .card_reset_out_o(card_reset_out_o), .card_clock_out_o(card_clock_out_o),
    .card_data_io_oe_o(card_data_io_oe_o), .card_supply_o(card_supply_o),
    .card_pulldown_o(card_pulldown_o), .device_active_o(device_active_o));
